// *** verilog/fdcm_regs.vh ***
// Opcode, field and result constants for the miscellaneous command decoder
`ifndef FDCM_REGS_VH
`define FDCM_REGS_VH
// ----------------------------------------
// Opcodes (low five bits, low seven bits, or full byte)
// ----------------------------------------
`define FDCM_OP_DUMPREG 8'h0E
`define FDCM_OP_READID 5'h0A
`define FDCM_OP_PERP 8'h12
`define FDCM_OP_LOCK 7'h14
`define FDCM_INVALID_RESULT 8'h80
`define FDCM_DUMP_LEN 4'hA
`define FDCM_SINGLE_LEN 4'h1
`define FDCM_READID_LEN 4'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FDCM_LOCK_BIT 7
`define FDCM_DD_BIT 6
`define FDCM_PERP_OW_BIT 7
`define FDCM_LOCK_RES_BIT 4
// ----------------------------------------
// Last data command kinds and reset values
// ----------------------------------------
`define FDCM_LAST_FORMAT 1'h1
`define FDCM_LAST_RDWR 1'h0
`define FDCM_LOCK_RST 1'h0
`define FDCM_PERP_RST 6'h00
`define FDCM_DSEL_RST 4'h0
`endif

// *** verilog/fdcm_misc_cmd.v ***
// Miscellaneous command decoder: dump registers, read ID, perpendicular, lock, invalid
`timescale 1ns/100ps
// What this block does
// [R1] Dump shared byte gives sectors-per-track when last data command was format.
// [R2] Dump shared byte gives end-of-track when last data command was read/write.
// [R3] Drive-select and perpendicular bits stay internal, never drive the select pins.
// [R4] Host keeps internal drive-select bits matching the digital output register pins.
// [R5] Undefined opcode is a no-op, goes standby, returns one byte 80H.
// [R6] Read ID captures the first valid sector ID on the current cylinder.
// [R7] Read ID returns status zero, one, two, then cylinder, head, sector, size.
// [R8] Decode dump, read ID, perpendicular, lock; lock result carries flag in bit 4.
`include "fdcm_regs.vh"
module fdcm_misc_cmd (
	input wire ref_clk,
	input wire nrst,
	input wire cmdValid,
	input wire [7:0] cmdByte,
	input wire resAck,
	input wire lastCmdFormat,
	input wire [31:0] presentCylinderNumber,
	input wire [7:0] stepHeadUnload,
	input wire [7:0] headLoadNoDma,
	input wire [7:0] sectorsPerTrackParam,
	input wire [7:0] endTrackSector,
	input wire [7:0] configByte,
	input wire [7:0] precompStartTrack,
	input wire idValid,
	input wire [7:0] idCyl,
	input wire [7:0] idHead,
	input wire [7:0] idSector,
	input wire [7:0] idSize,
	input wire [7:0] statusByteZero,
	input wire [7:0] statusByteOne,
	input wire [7:0] statusByteTwo,
	output reg cmdReady,
	output reg resValid,
	output reg [7:0] resByte,
	output reg idSearchReq,
	output reg [1:0] idDrive,
	output reg idHeadSel,
	output reg idDoubleDensity,
	output reg standby,
	output reg lockFlag,
	output reg [5:0] perpSetting,
	output reg [3:0] driveSelInternal
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_ARG = 3'h1;
	localparam ST_SEARCH = 3'h2;
	localparam ST_RESULT = 3'h3;
	localparam KIND_DUMP = 2'h0;
	localparam KIND_RDID = 2'h1;
	localparam KIND_LOCK = 2'h2;
	localparam KIND_INV = 2'h3;

	reg [2:0] state_reg;
	reg [1:0] kind_reg;
	reg [3:0] idx_reg;
	reg [3:0] len_reg;
	reg perpArg_reg;
	reg [7:0] cId_reg;
	reg [7:0] hId_reg;
	reg [7:0] rId_reg;
	reg [7:0] nId_reg;
	reg [7:0] byte_next;

	// Opcode classifier, used for first byte decode
	function [1:0] opClass;
		input [7:0] op;
		begin
			if (op == `FDCM_OP_DUMPREG)
				opClass = 2'h0;
			else if (op[4:0] == `FDCM_OP_READID && op[7] == 1'b0 && op[5] == 1'b0)
				opClass = 2'h1;
			else if (op[6:0] == `FDCM_OP_LOCK)
				opClass = 2'h2;
			else
				opClass = 2'h3;
		end
	endfunction

	// Result byte selection by kind and index
	always @* begin
		byte_next = 8'h00;
		case (kind_reg)
			KIND_DUMP: begin
				case (idx_reg)
					4'h0: byte_next = presentCylinderNumber[7:0];
					4'h1: byte_next = presentCylinderNumber[15:8];
					4'h2: byte_next = presentCylinderNumber[23:16];
					4'h3: byte_next = presentCylinderNumber[31:24];
					4'h4: byte_next = stepHeadUnload;
					4'h5: byte_next = headLoadNoDma;
					// [R1] [R2] Shared byte choice
					4'h6: byte_next = (lastCmdFormat == `FDCM_LAST_FORMAT) ? sectorsPerTrackParam : endTrackSector;
					4'h7: byte_next = {lockFlag, 1'b0, driveSelInternal, perpSetting[1:0]};
					4'h8: byte_next = {1'b0, configByte[6:0]};
					4'h9: byte_next = precompStartTrack;
					default: byte_next = 8'h00;
				endcase
			end
			KIND_RDID: begin
				// [R7] Seven byte order
				case (idx_reg)
					4'h0: byte_next = statusByteZero;
					4'h1: byte_next = statusByteOne;
					4'h2: byte_next = statusByteTwo;
					4'h3: byte_next = cId_reg;
					4'h4: byte_next = hId_reg;
					4'h5: byte_next = rId_reg;
					4'h6: byte_next = nId_reg;
					default: byte_next = 8'h00;
				endcase
			end
			// [R8] Lock flag bit 4
			KIND_LOCK: byte_next = {3'h0, lockFlag, 4'h0};
			// [R5] Single 80H byte
			KIND_INV: byte_next = `FDCM_INVALID_RESULT;
			default: byte_next = 8'h00;
		endcase
	end

	// Command sequencer
	always @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			kind_reg <= KIND_DUMP;
			idx_reg <= 4'h0;
			len_reg <= 4'h0;
			perpArg_reg <= 1'b0;
			cId_reg <= 8'h00;
			hId_reg <= 8'h00;
			rId_reg <= 8'h00;
			nId_reg <= 8'h00;
			cmdReady <= 1'b1;
			resValid <= 1'b0;
			resByte <= 8'h00;
			idSearchReq <= 1'b0;
			idDrive <= 2'h0;
			idHeadSel <= 1'b0;
			idDoubleDensity <= 1'b0;
			standby <= 1'b0;
			lockFlag <= `FDCM_LOCK_RST;
			perpSetting <= `FDCM_PERP_RST;
			driveSelInternal <= `FDCM_DSEL_RST;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cmdValid) begin
						standby <= 1'b0;
						idx_reg <= 4'h0;
						// [R8] Opcode decode
						if (cmdByte == `FDCM_OP_PERP) begin
							perpArg_reg <= 1'b1;
							state_reg <= ST_ARG;
						end else begin
							kind_reg <= opClass(cmdByte);
							case (opClass(cmdByte))
								KIND_DUMP: begin
									len_reg <= `FDCM_DUMP_LEN;
									cmdReady <= 1'b0;
									state_reg <= ST_RESULT;
								end
								KIND_RDID: begin
									idDoubleDensity <= cmdByte[`FDCM_DD_BIT];
									perpArg_reg <= 1'b0;
									state_reg <= ST_ARG;
								end
								KIND_LOCK: begin
									lockFlag <= cmdByte[`FDCM_LOCK_BIT];
									len_reg <= `FDCM_SINGLE_LEN;
									cmdReady <= 1'b0;
									state_reg <= ST_RESULT;
								end
								default: begin
									// [R5] No-op into standby
									standby <= 1'b1;
									len_reg <= `FDCM_SINGLE_LEN;
									cmdReady <= 1'b0;
									state_reg <= ST_RESULT;
								end
							endcase
						end
					end
				end
				ST_ARG: begin
					if (cmdValid) begin
						if (perpArg_reg) begin
							// [R3] Internal only store
							if (cmdByte[`FDCM_PERP_OW_BIT])
								driveSelInternal <= cmdByte[5:2];
							perpSetting <= cmdByte[5:0];
							state_reg <= ST_IDLE;
						end else begin
							idDrive <= cmdByte[1:0];
							idHeadSel <= cmdByte[2];
							idSearchReq <= 1'b1;
							cmdReady <= 1'b0;
							state_reg <= ST_SEARCH;
						end
					end
				end
				ST_SEARCH: begin
					// [R6] First valid ID
					if (idValid) begin
						cId_reg <= idCyl;
						hId_reg <= idHead;
						rId_reg <= idSector;
						nId_reg <= idSize;
						idSearchReq <= 1'b0;
						len_reg <= `FDCM_READID_LEN;
						state_reg <= ST_RESULT;
					end
				end
				ST_RESULT: begin
					if (!resValid) begin
						resByte <= byte_next;
						resValid <= 1'b1;
					end else if (resAck) begin
						resValid <= 1'b0;
						if (idx_reg + 4'h1 == len_reg) begin
							cmdReady <= 1'b1;
							state_reg <= ST_IDLE;
						end else begin
							idx_reg <= idx_reg + 4'h1;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // fdcm_misc_cmd

// *** dv/fdcm_misc_asserts.sv ***
// Port checks for the miscellaneous command decoder
`timescale 1ns/100ps
module fdcm_misc_asserts (
	input wire ref_clk,
	input wire nrst,
	input wire cmdValid,
	input wire [7:0] cmdByte,
	input wire resAck,
	input wire idValid,
	input wire cmdReady,
	input wire resValid,
	input wire [7:0] resByte,
	input wire idSearchReq,
	input wire standby,
	input wire [3:0] driveSelInternal
);
	reg perpPend;
	reg idPend;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Tracks when the next accepted byte is a second byte, not an opcode
	always @(posedge ref_clk) begin
		if (!nrst) begin
			perpPend <= 1'b0;
			idPend <= 1'b0;
		end else if (cmdReady && cmdValid) begin
			perpPend <= !perpPend && !idPend && cmdByte == 8'h12;
			idPend <= !perpPend && !idPend && cmdByte[7] == 1'b0 && cmdByte[5:0] == 6'h0A;
		end
	end
	a_lock_result:
	assert property (cmdReady && cmdValid && !perpPend && !idPend && cmdByte[6:0] == 7'h14 |-> ##2 resValid
		&& resByte == {3'h0, $past(cmdByte[7], 2), 4'h0}) else $error("lock");
	a_invalid_code:
	assert property (cmdReady && cmdValid && !perpPend && !idPend && cmdByte == 8'hFF |-> ##2 resValid
		&& resByte == 8'h80 && standby) else $error("invalid");
	a_result_hold:
	assert property (resValid && !resAck |=> resValid && $stable(resByte)) else $error("hold");
	a_ack_gap:
	assert property (resValid && resAck |=> !resValid) else $error("ack");
	a_id_answer:
	assert property (idSearchReq && idValid |=> !idSearchReq ##[0:2] resValid) else $error("id");
	a_select_internal:
	assert property ($changed(driveSelInternal) |-> $past(perpPend) && $past(cmdValid) && $past(cmdByte[7])
		&& driveSelInternal == $past(cmdByte[5:2])) else $error("select");
	a_select_store:
	assert property (perpPend && cmdValid && cmdByte[7] |=> driveSelInternal == $past(cmdByte[5:2]))
		else $error("store");
endmodule // fdcm_misc_asserts
bind fdcm_misc_cmd fdcm_misc_asserts fdcm_misc_asserts_inst (.ref_clk, .nrst, .cmdValid, .cmdByte, .resAck,
	.idValid, .cmdReady, .resValid, .resByte, .idSearchReq, .standby, .driveSelInternal);

// *** dv/fdcm_id_model.sv ***
// Drive-side model answering an ID search with one sector ID
`timescale 1ns/100ps
module fdcm_id_model (
	input wire ref_clk,
	input wire idSearchReq,
	output reg idValid,
	output wire [7:0] idCyl,
	output wire [7:0] idHead,
	output wire [7:0] idSector,
	output wire [7:0] idSize
);
	reg [3:0] waitCnt = 4'h0;
	initial idValid = 1'b0;
	always @(posedge ref_clk) begin
		waitCnt <= idSearchReq ? waitCnt + 4'h1 : 4'h0;
		idValid <= idSearchReq && waitCnt == 4'h6;
	end
	// Fields change every cycle while a search is requested, outside the pulse
	assign {idCyl, idHead, idSector, idSize} = idValid ? 32'h11223302 : {8{waitCnt}};
endmodule // fdcm_id_model

// *** dv/testbench.sv ***
// Bench sending command bytes and checking result bytes
`timescale 1ns/100ps
module testbench;
	reg ref_clk = 0, nrst = 0, cmdValid = 0, resAck = 0, lastCmdFormat = 1;
	reg [7:0] cmdByte = 8'h00, b = 8'h30;
	wire idValid, cmdReady, resValid, idSearchReq, idHeadSel, idDoubleDensity, standby, lockFlag;
	wire [7:0] idCyl, idHead, idSector, idSize, resByte;
	wire [1:0] idDrive;
	wire [3:0] driveSelInternal;
	wire [5:0] perpSetting;
	integer fails = 0, comparisons = 0, n;
	always #10 ref_clk = ~ref_clk;
	fdcm_misc_cmd fdcm_misc_cmd_inst (.ref_clk, .nrst, .cmdValid, .cmdByte, .resAck, .lastCmdFormat,
		.presentCylinderNumber({4{b}} ^ 32'h0D0C0B0A), .stepHeadUnload(b ^ 8'h11), .headLoadNoDma(b ^ 8'h22),
		.sectorsPerTrackParam(b ^ 8'h33), .endTrackSector(b ^ 8'h44), .configByte(b ^ 8'hD5),
		.precompStartTrack(b ^ 8'h66), .idValid, .idCyl, .idHead, .idSector, .idSize, .statusByteZero(b ^ 8'h01),
		.statusByteOne(b ^ 8'h02), .statusByteTwo(b ^ 8'h03), .cmdReady, .resValid, .resByte, .idSearchReq,
		.idDrive, .idHeadSel, .idDoubleDensity, .standby, .lockFlag, .perpSetting, .driveSelInternal);
	fdcm_id_model fdcm_id_model_inst (.ref_clk, .idSearchReq, .idValid, .idCyl, .idHead, .idSector, .idSize);
	task conclude; begin
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	end endtask
	task chk(input [7:0] g, input [7:0] e); begin
		comparisons = comparisons + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	end endtask
	// Bounded wait for ready or result at falling edges
	task wt(input m); integer k; begin
		k = 0;
		while ((m ? resValid : cmdReady) !== 1'b1 && k < 99) begin
			@(negedge ref_clk);
			k = k + 1;
		end
		if ((m ? resValid : cmdReady) !== 1'b1) begin
			fails = fails + 1;
			$display("Error %0t: wait timed out", $time);
			conclude;
		end
	end endtask
	// Opcode, optional second byte, then m result bytes
	task op(input [7:0] c, input [7:0] a, input t, input [79:0] v, input integer m); integer j; begin
		@(negedge ref_clk);
		wt(0);
		cmdByte = c;
		cmdValid = 1;
		if (t) @(negedge ref_clk) cmdByte = a;
		@(negedge ref_clk) cmdValid = 0;
		for (j = 0; j < m; j = j + 1) begin
			wt(1);
			chk(resByte, v[8 * (m - 1 - j) +: 8]);
			resAck = 1;
			@(negedge ref_clk) resAck = 0;
		end
	end endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		nrst = 1;
		op(8'h94, 8'h00, 0, 80'h10, 1);
		op(8'h12, 8'hBF, 1, 80'h0, 0);
		op(8'h12, 8'h3C, 1, 80'h0, 0);
		for (n = 0; n < 2; n = n + 1) begin
			lastCmdFormat = n == 0;
			op(8'h0E, 8'h00, 0, {{4{b}} ^ 32'h0A0B0C0D, b ^ 8'h11, b ^ 8'h22, b ^ (n ? 8'h44 : 8'h33), 8'hBC,
				(b ^ 8'hD5) & 8'h7F, b ^ 8'h66}, 10);
		end
		chk({4'h0, driveSelInternal}, 8'h0F);
		chk({2'h0, perpSetting}, 8'h3C);
		op(8'hFF, 8'h00, 0, 80'h80, 1);
		chk({7'h00, standby}, 8'h01);
		op(8'h14, 8'h00, 0, 80'h00, 1);
		chk({6'h00, standby, lockFlag}, 8'h00);
		op(8'h4A, 8'h05, 1, {b ^ 8'h01, b ^ 8'h02, b ^ 8'h03, 32'h11223302}, 7);
		chk({4'h0, idDoubleDensity, idHeadSel, idDrive}, 8'h0D);
		conclude;
	end
endmodule // testbench
